// File: design/ldorc_pkg.sv
// Purpose: shared constants for the rail control register bank
// Assumes: 8-bit registers reached by a simple synchronous register port
// Notes:   offsets, reset values, field positions and state codes live here
package ldorc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] LDORC_OFF_AOEXIT = 8'h3D;
  localparam logic [7:0] LDORC_OFF_MEM    = 8'h3E;
  localparam logic [7:0] LDORC_OFF_AON    = 8'h45;
  localparam logic [7:0] LDORC_OFF_AUX    = 8'h47;
  localparam logic [7:0] LDORC_OFF_IO     = 8'h4A;
  localparam logic [7:0] LDORC_OFF_MODEM  = 8'h4B;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] LDORC_RST_AOEXIT = 8'h07;
  localparam logic [7:0] LDORC_RST_MEM    = 8'h3C;
  localparam logic [7:0] LDORC_RST_AON    = 8'h07;
  localparam logic [7:0] LDORC_RST_AUX    = 8'h24;
  localparam logic [7:0] LDORC_RST_IO     = 8'h24;
  localparam logic [7:0] LDORC_RST_MODEM  = 8'h24;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LDORC_STATE_LSB = 0;
  localparam int LDORC_EXIT_LSB  = 3;
  localparam int LDORC_SEL_LSB   = 6;
  localparam int LDORC_NUM_RAILS = 6;

  // rail indices inside the bank
  localparam int LDORC_IX_AOEXIT = 0;
  localparam int LDORC_IX_MEM    = 1;
  localparam int LDORC_IX_AON    = 2;
  localparam int LDORC_IX_AUX    = 3;
  localparam int LDORC_IX_IO     = 4;
  localparam int LDORC_IX_MODEM  = 5;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [2:0] LDORC_CODE_OFF  = 3'h4;
  localparam logic [2:0] LDORC_CODE_LOWP = 3'h5;
  localparam logic [1:0] LDORC_SEL_LO    = 2'h0;  // io 1.8 V, modem 1.2 V
  localparam logic [1:0] LDORC_SEL_HI    = 2'h1;  // io 2.5 V, modem 1.3 V

  // decoded rail mode
  typedef enum logic [1:0] {
    LDORC_MODE_OFF    = 2'h0,
    LDORC_MODE_LOWP   = 2'h1,
    LDORC_MODE_ACTIVE = 2'h3
  } ldorc_mode_t;

  // physical regulator voltage setting
  typedef enum logic [1:0] {
    LDORC_V_NONE = 2'h0,
    LDORC_V_1P8  = 2'h1,
    LDORC_V_2P5  = 2'h2,
    LDORC_V_1P2  = 2'h3
  } ldorc_volt_t;
  localparam logic [1:0] LDORC_V_1P3 = 2'h3;  // navigation side shares encoding slot

  // state field decode: reserved codes fall to off
  function automatic ldorc_mode_t ldorc_decode(input logic [2:0] code);
    ldorc_mode_t m;
    m = LDORC_MODE_OFF;
    if (code == LDORC_CODE_LOWP) begin
      m = LDORC_MODE_LOWP;
    end else if (code[2] && code[1]) begin
      m = LDORC_MODE_ACTIVE;
    end
    return m;
  endfunction

endpackage

// File: design/ldorc_rail_if.sv
// Purpose: per-rail control bundle between bank and rail drivers
// Assumes: one clock domain
// Notes:   state code in, decoded controls out
`timescale 1ns/10ps
interface ldorc_rail_if;
  import ldorc_pkg::*;
  logic [2:0]  state_code;
  ldorc_mode_t mode;
  logic        discharge;

  modport bank (output state_code, input mode, input discharge);
  modport rail (input state_code, output mode, output discharge);
endinterface

// File: design/ldorc_rail_dec.sv
// Purpose: decode one rail's state field into enable, low power, discharge
// Assumes: state code already registered in the bank
// Notes:   purely combinational; the bank registers the results
`timescale 1ns/10ps
module ldorc_rail_dec
  import ldorc_pkg::*;
(
  ldorc_rail_if.rail rail_if
);
  // reserved codes decode to off so nothing turns on by accident
  always_comb begin
    rail_if.mode      = ldorc_decode(rail_if.state_code);
    rail_if.discharge = (ldorc_decode(rail_if.state_code) == LDORC_MODE_OFF);
  end
endmodule

// File: design/ldorc_bank.sv
// Purpose: control register bank for a group of linear regulator rails
// Assumes: register port is synchronous; one access per cycle; pins synchronous
// Notes:   the two mapped rails steer the wireless and navigation regulators
//
// Summary of operation
// - state code 4 off, 5 low, 6-7 active
// - standby exit copies exit field if 4-7
// - io select: 0 is 1.8 V, 1 is 2.5 V
// - modem select: 0 is 1.2 V, 1 is 1.3 V
// - io 1.8 V drives navigation regulator
// - io 2.5 V drives wireless regulator
// - modem 1.2 V drives wireless regulator
// - modem 1.3 V drives navigation regulator
// - mapped registers reset 0x24, read/write
// - processor rail registers reset 0x07, 0x3C
// - always-on 0x07, auxiliary 0x24, read/write
// - shut-down rails are actively discharged
// - over-current and under-voltage reported as faults
`timescale 1ns/10ps
module ldorc_bank
  import ldorc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              standby_exit_pin_in,
  input  wire logic [5:0]        ocp_in,
  input  wire logic [5:0]        uvp_in,
  output logic [7:0]             reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic [3:0]             rail_en_out,
  output logic [3:0]             rail_lowp_out,
  output logic [3:0]             rail_disch_out,
  output logic                   wireless_regulator_en_out,
  output logic                   wireless_regulator_lowp_out,
  output logic                   wireless_regulator_disch_out,
  output ldorc_volt_t            wireless_regulator_volt_out,
  output logic                   navigation_regulator_en_out,
  output logic                   navigation_regulator_lowp_out,
  output logic                   navigation_regulator_disch_out,
  output logic [1:0]             navigation_regulator_volt_out,
  output logic [5:0]             fault_event_out
);

  // an address too narrow to reach the top register cannot be served
  generate
    if (ADDR_W < 7) begin : g_addr_w_check
      $error("ldorc_bank: address must reach offset 0x4B");
    end
  endgenerate

  // ****************************************************************
  // register storage
  // ****************************************************************
  localparam logic [7:0] RST_VAL [LDORC_NUM_RAILS] = '{
    LDORC_RST_AOEXIT, LDORC_RST_MEM, LDORC_RST_AON,
    LDORC_RST_AUX, LDORC_RST_IO, LDORC_RST_MODEM
  };
  localparam logic [7:0] OFF_VAL [LDORC_NUM_RAILS] = '{
    LDORC_OFF_AOEXIT, LDORC_OFF_MEM, LDORC_OFF_AON,
    LDORC_OFF_AUX, LDORC_OFF_IO, LDORC_OFF_MODEM
  };

  logic [7:0] ctrl_reg  [LDORC_NUM_RAILS];
  logic [7:0] ctrl_next [LDORC_NUM_RAILS];
  logic [LDORC_NUM_RAILS-1:0] hit;

  // address decode, one hit line per register
  always_comb begin
    for (int i = 0; i < LDORC_NUM_RAILS; i++) begin
      hit[i] = (reg_addr_in == ADDR_W'(OFF_VAL[i]));
    end
  end

  // a register write wins over a standby copy in the same cycle, since the
  // host's newest intent is the one it expects to read back
  always_comb begin
    for (int i = 0; i < LDORC_NUM_RAILS; i++) begin
      ctrl_next[i] = ctrl_reg[i];
      if (standby_exit_pin_in && ctrl_reg[i][LDORC_EXIT_LSB+2]) begin
        ctrl_next[i][LDORC_STATE_LSB+:3] = ctrl_reg[i][LDORC_EXIT_LSB+:3];
      end
      if (reg_wr_in && hit[i]) begin
        ctrl_next[i] = reg_wdata_in;
      end
    end
  end

  // bank registers, reset to their documented defaults
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < LDORC_NUM_RAILS; i++) begin
      if (srst_in) begin
        ctrl_reg[i] <= RST_VAL[i];
      end else begin
        ctrl_reg[i] <= ctrl_next[i];
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] rdata_next;
  logic       rvalid_next;

  // unmapped addresses read as zero
  always_comb begin
    rdata_next  = 8'h00;
    rvalid_next = reg_rd_in;
    for (int i = 0; i < LDORC_NUM_RAILS; i++) begin
      if (reg_rd_in && hit[i]) begin
        rdata_next = ctrl_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out  <= rdata_next;
      reg_rvalid_out <= rvalid_next;
    end
  end

  // ****************************************************************
  // per-rail state decode
  // ****************************************************************
  ldorc_mode_t mode_w  [LDORC_NUM_RAILS];
  logic        disch_w [LDORC_NUM_RAILS];

  genvar g;
  generate
    for (g = 0; g < LDORC_NUM_RAILS; g++) begin : g_rail
      ldorc_rail_if rif ();
      assign rif.state_code = ctrl_reg[g][LDORC_STATE_LSB+:3];
      ldorc_rail_dec u_dec (
        .rail_if (rif.rail)
      );
      assign mode_w[g]  = rif.mode;
      assign disch_w[g] = rif.discharge;
    end
  endgenerate

  // ****************************************************************
  // fixed rails and mapped rail steering
  // ****************************************************************
  logic [3:0]  en_next;
  logic [3:0]  lowp_next;
  logic [3:0]  disch_next;
  logic        wl_en_next;
  logic        wl_lowp_next;
  ldorc_volt_t wl_volt_next;
  logic        nv_en_next;
  logic        nv_lowp_next;
  logic [1:0]  nv_volt_next;
  logic [1:0]  io_sel;
  logic [1:0]  md_sel;

  // reserved select codes steer nothing; an unsteered regulator is held off
  // and discharged, which is the safe state if firmware slips
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      en_next[i]    = (mode_w[i] != LDORC_MODE_OFF);
      lowp_next[i]  = (mode_w[i] == LDORC_MODE_LOWP);
      disch_next[i] = disch_w[i];
    end
    io_sel       = ctrl_reg[LDORC_IX_IO][LDORC_SEL_LSB+:2];
    md_sel       = ctrl_reg[LDORC_IX_MODEM][LDORC_SEL_LSB+:2];
    wl_en_next   = 1'b0;
    wl_lowp_next = 1'b0;
    wl_volt_next = LDORC_V_NONE;
    nv_en_next   = 1'b0;
    nv_lowp_next = 1'b0;
    nv_volt_next = LDORC_V_NONE;
    if (io_sel == LDORC_SEL_LO) begin
      nv_en_next   = (mode_w[LDORC_IX_IO] != LDORC_MODE_OFF);
      nv_lowp_next = (mode_w[LDORC_IX_IO] == LDORC_MODE_LOWP);
      nv_volt_next = LDORC_V_1P8;
    end else if (io_sel == LDORC_SEL_HI) begin
      wl_en_next   = (mode_w[LDORC_IX_IO] != LDORC_MODE_OFF);
      wl_lowp_next = (mode_w[LDORC_IX_IO] == LDORC_MODE_LOWP);
      wl_volt_next = LDORC_V_2P5;
    end
    // the host keeps the two mapped rails apart; if it does not, the
    // modem side takes the shared regulator
    if (md_sel == LDORC_SEL_LO) begin
      wl_en_next   = (mode_w[LDORC_IX_MODEM] != LDORC_MODE_OFF);
      wl_lowp_next = (mode_w[LDORC_IX_MODEM] == LDORC_MODE_LOWP);
      wl_volt_next = LDORC_V_1P2;
    end else if (md_sel == LDORC_SEL_HI) begin
      nv_en_next   = (mode_w[LDORC_IX_MODEM] != LDORC_MODE_OFF);
      nv_lowp_next = (mode_w[LDORC_IX_MODEM] == LDORC_MODE_LOWP);
      nv_volt_next = LDORC_V_1P3;
    end
  end

  // registered regulator controls and fault events
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rail_en_out                    <= 4'h0;
      rail_lowp_out                  <= 4'h0;
      rail_disch_out                 <= 4'hF;
      wireless_regulator_en_out      <= 1'b0;
      wireless_regulator_lowp_out    <= 1'b0;
      wireless_regulator_disch_out   <= 1'b1;
      wireless_regulator_volt_out    <= LDORC_V_NONE;
      navigation_regulator_en_out    <= 1'b0;
      navigation_regulator_lowp_out  <= 1'b0;
      navigation_regulator_disch_out <= 1'b1;
      navigation_regulator_volt_out  <= 2'h0;
      fault_event_out                <= 6'h00;
    end else begin
      rail_en_out                    <= en_next;
      rail_lowp_out                  <= lowp_next;
      rail_disch_out                 <= disch_next;
      wireless_regulator_en_out      <= wl_en_next;
      wireless_regulator_lowp_out    <= wl_lowp_next;
      wireless_regulator_disch_out   <= !wl_en_next;
      wireless_regulator_volt_out    <= wl_volt_next;
      navigation_regulator_en_out    <= nv_en_next;
      navigation_regulator_lowp_out  <= nv_lowp_next;
      navigation_regulator_disch_out <= !nv_en_next;
      navigation_regulator_volt_out  <= nv_volt_next;
      fault_event_out                <= ocp_in | uvp_in;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_exit_copy_taken: assert property (@(posedge clk_in) disable iff (srst_in)
    (standby_exit_pin_in && !reg_wr_in && ctrl_reg[LDORC_IX_AOEXIT][5])
    |=> ctrl_reg[LDORC_IX_AOEXIT][2:0] == $past(ctrl_reg[LDORC_IX_AOEXIT][5:3]))
    else $error("standby exit copy missing");

  chk_exit_nocopy_held: assert property (@(posedge clk_in) disable iff (srst_in)
    (standby_exit_pin_in && !reg_wr_in && !ctrl_reg[LDORC_IX_AUX][5])
    |=> $stable(ctrl_reg[LDORC_IX_AUX]))
    else $error("exit code 0-3 changed state");

  chk_write_readback: assert property (@(posedge clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == ADDR_W'(LDORC_OFF_IO)) ##1
    (!reg_wr_in && !standby_exit_pin_in) ##1
    (reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_W'(LDORC_OFF_IO))
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("io register readback wrong");

  chk_reset_value: assert property (@(posedge clk_in)
    $past(srst_in) |-> ctrl_reg[LDORC_IX_MEM] == LDORC_RST_MEM)
    else $error("memory rail reset value wrong");

  chk_off_discharge: assert property (@(posedge clk_in) disable iff (srst_in)
    rail_disch_out[LDORC_IX_AON] == !rail_en_out[LDORC_IX_AON])
    else $error("discharge not tied to off");

  chk_io_nav_1p8: assert property (@(posedge clk_in) disable iff (srst_in)
    (io_sel == LDORC_SEL_LO && md_sel != LDORC_SEL_HI && ctrl_reg[LDORC_IX_IO][2:1] == 2'h3)
    |=> navigation_regulator_en_out && navigation_regulator_volt_out == LDORC_V_1P8)
    else $error("io 1.8 V not on navigation");

  chk_modem_wl_1p2: assert property (@(posedge clk_in) disable iff (srst_in)
    (md_sel == LDORC_SEL_LO && ctrl_reg[LDORC_IX_MODEM][2:0] == LDORC_CODE_LOWP)
    |=> wireless_regulator_lowp_out && wireless_regulator_volt_out == LDORC_V_1P2)
    else $error("modem 1.2 V not on wireless");

  chk_reserved_off: assert property (@(posedge clk_in) disable iff (srst_in)
    (!ctrl_reg[LDORC_IX_AOEXIT][2]) |=> !rail_en_out[LDORC_IX_AOEXIT])
    else $error("reserved code enabled a rail");

  chk_fault_report: assert property (@(posedge clk_in) disable iff (srst_in)
    (ocp_in[0] || uvp_in[0]) |=> fault_event_out[0])
    else $error("fault not reported");

  // steering checks look one edge on, since regulator controls are registered
  chk_read_answer: assert property (@(posedge clk_in) disable iff (srst_in)
    reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");

  chk_io_wl_2p5: assert property (@(posedge clk_in) disable iff (srst_in)
    (io_sel == LDORC_SEL_HI && md_sel != LDORC_SEL_LO && ctrl_reg[LDORC_IX_IO][2:1] == 2'h3)
    |=> wireless_regulator_en_out && wireless_regulator_volt_out == LDORC_V_2P5)
    else $error("io 2.5 V not on wireless");

  chk_modem_nav_1p3: assert property (@(posedge clk_in) disable iff (srst_in)
    (md_sel == LDORC_SEL_HI && ctrl_reg[LDORC_IX_MODEM][2:1] == 2'h3)
    |=> navigation_regulator_en_out && navigation_regulator_volt_out == LDORC_V_1P3)
    else $error("modem 1.3 V not on navigation");

  chk_reserved_sel: assert property (@(posedge clk_in) disable iff (srst_in)
    (io_sel[1] && md_sel[1]) |=> !wireless_regulator_en_out && !navigation_regulator_en_out)
    else $error("reserved select enabled a regulator");

  chk_lowp_state: assert property (@(posedge clk_in) disable iff (srst_in)
    (ctrl_reg[LDORC_IX_MEM][2:0] == LDORC_CODE_LOWP)
    |=> rail_en_out[LDORC_IX_MEM] && rail_lowp_out[LDORC_IX_MEM])
    else $error("low power code not decoded");

  chk_nav_discharge: assert property (@(posedge clk_in) disable iff (srst_in)
    navigation_regulator_disch_out == !navigation_regulator_en_out)
    else $error("navigation discharge not tied to off");

endmodule

// File: sim/ldorc_host_model.sv
// Purpose: host-side register master that programs the rail bank
// Assumes: register port takes a request on the rising edge, read answers one cycle later
// Notes:   drives just after each edge and holds until the taking edge has passed
`timescale 1ns/10ps
module ldorc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out
);
  // ****************************************************************
  // idle bus
  // ****************************************************************
  initial begin
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
  end

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // one write; data is inverted on release so no stale value looks valid
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    #1;
    reg_wr_out    = 1'b1;
    reg_addr_out  = addr;
    reg_wdata_out = data;
    @(posedge clk_in);
    #1;
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~data;
  endtask

  // one read; answer is taken in the cycle it stands
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
    @(posedge clk_in);
    #1;
    reg_rd_out   = 1'b1;
    reg_addr_out = addr;
    @(posedge clk_in);
    #1;
    reg_rd_out   = 1'b0;
    data         = reg_rdata_in;
    vld          = reg_rvalid_in;
    reg_addr_out = ~addr;
  endtask
endmodule

// File: sim/ldorc_bank_tb_top.sv
// Purpose: self-checking bench for the rail control register bank
// Assumes: one clock at 10 MHz, synchronous active-high reset
// Notes:   host never lets both mapped rails claim one regulator
`timescale 1ns/10ps
module ldorc_bank_tb_top
  import ldorc_pkg::*;
;
  logic        clk_in;
  logic        srst_in;
  logic        pin;
  logic [5:0]  ocp;
  logic [5:0]  uvp;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [3:0]  en;
  logic [3:0]  lowp;
  logic [3:0]  disch;
  logic        wl_en;
  logic        wl_lowp;
  logic        wl_disch;
  ldorc_volt_t wl_volt;
  logic        nv_en;
  logic        nv_lowp;
  logic        nv_disch;
  logic [1:0]  nv_volt;
  logic [5:0]  fault;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;
  logic [7:0]  offs [6] = '{8'h3D, 8'h3E, 8'h45, 8'h47, 8'h4A, 8'h4B};
  logic [7:0]  rsts [6] = '{8'h07, 8'h3C, 8'h07, 8'h24, 8'h24, 8'h24};
  // mapping rows: modem value, io value, expected, compare mask
  logic [7:0]  map_m [4] = '{8'h05, 8'h47, 8'hC6, 8'h06};
  logic [7:0]  map_i [4] = '{8'h06, 8'h46, 8'h84, 8'h04};
  logic [7:0]  map_e [4] = '{8'h9F, 8'hBA, 8'h00, 8'h0B};
  logic [7:0]  map_k [4] = '{8'hFF, 8'hFF, 8'h88, 8'h8F};

  ldorc_host_model i_ldorc_host_model (
    .clk_in        (clk_in),
    .reg_rdata_in  (rdata),
    .reg_rvalid_in (rvalid),
    .reg_wr_out    (wr),
    .reg_rd_out    (rd),
    .reg_addr_out  (addr),
    .reg_wdata_out (wdata)
  );

  ldorc_bank i_ldorc_bank (
    .clk_in (clk_in), .srst_in (srst_in), .reg_wr_in (wr), .reg_rd_in (rd),
    .reg_addr_in (addr), .reg_wdata_in (wdata), .standby_exit_pin_in (pin),
    .ocp_in (ocp), .uvp_in (uvp), .reg_rdata_out (rdata), .reg_rvalid_out (rvalid),
    .rail_en_out (en), .rail_lowp_out (lowp), .rail_disch_out (disch),
    .wireless_regulator_en_out (wl_en), .wireless_regulator_lowp_out (wl_lowp),
    .wireless_regulator_disch_out (wl_disch), .wireless_regulator_volt_out (wl_volt),
    .navigation_regulator_en_out (nv_en), .navigation_regulator_lowp_out (nv_lowp),
    .navigation_regulator_disch_out (nv_disch), .navigation_regulator_volt_out (nv_volt),
    .fault_event_out (fault)
  );

  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_ldorc_host_model.rd(a, d, v);
    check({7'h0, v}, 8'h01);
    check(d, exp);
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [2:0] c;
    logic       e;
    srst_in = 1'b1;
    pin     = 1'b0;
    ocp     = 6'h00;
    uvp     = 6'h00;
    repeat (4) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    // defaults, then an unmapped write that must be ignored
    for (int i = 0; i < 6; i++) rd_chk(offs[i], rsts[i]);
    check({en, disch}, 8'h5A);
    i_ldorc_host_model.wr(8'h46, 8'hFF);
    rd_chk(8'h46, 8'h00);
    // every bit writable, upper bits kept as written
    for (int i = 0; i < 6; i++) i_ldorc_host_model.wr(offs[i], {2'h3, 3'(i), 3'h4});
    for (int i = 0; i < 6; i++) rd_chk(offs[i], {2'h3, 3'(i), 3'h4});
    // every state code on every plain rail; reserved codes enable nothing
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 8; k++) begin
        c = 3'(k);
        e = (c >= 3'h5);
        i_ldorc_host_model.wr(offs[r], {5'h00, c});
        @(posedge clk_in);
        #1;
        check({5'h00, en[r], lowp[r], disch[r]}, {5'h00, e, c == 3'h5, !e});
      end
    end
    // mapped rails; io parks on a reserved select first so no regulator is shared
    for (int i = 0; i < 4; i++) begin
      i_ldorc_host_model.wr(LDORC_OFF_IO, 8'h80);
      i_ldorc_host_model.wr(LDORC_OFF_MODEM, map_m[i]);
      i_ldorc_host_model.wr(LDORC_OFF_IO, map_i[i]);
      @(posedge clk_in);
      #1;
      check({nv_en, nv_lowp, nv_volt, wl_en, wl_lowp, wl_volt} & map_k[i], map_e[i]);
      check({6'h00, nv_disch, wl_disch}, {6'h00, !map_e[i][7], !map_e[i][3]});
    end
    // io write then read; reserved select keeps clear of the modem's regulator
    i_ldorc_host_model.wr(LDORC_OFF_IO, 8'hA5);
    rd_chk(LDORC_OFF_IO, 8'hA5);
    // exit fields set up before any standby exit, then one exit edge
    i_ldorc_host_model.wr(8'h3D, 8'h34);
    i_ldorc_host_model.wr(8'h3E, 8'h3C);
    i_ldorc_host_model.wr(8'h45, 8'h1D);
    @(posedge clk_in);
    #1;
    pin = 1'b1;
    @(posedge clk_in);
    #1;
    pin = 1'b0;
    rd_chk(8'h3D, 8'h36);
    rd_chk(8'h3E, 8'h3F);
    rd_chk(8'h45, 8'h1D);
    check({en, lowp}, 8'hF4);
    // each rail's fault inputs reach its own event bit
    for (int i = 0; i < 6; i++) begin
      ocp = 6'h01 << i;
      uvp = 6'h20 >> i;
      @(posedge clk_in);
      #1;
      check({2'h0, fault}, {2'h0, (6'h01 << i) | (6'h20 >> i)});
    end
    ocp = 6'h00;
    uvp = 6'h00;
    @(posedge clk_in);
    #1;
    check({2'h0, fault}, 8'h00);
    tally_and_finish();
  end
endmodule
